// >>> isolated_input_spi_irq_front.v
// Behaviour
// - slave only on four-wire serial port, 16-bit reads and writes.
// - chip select rising mid-transfer abandons it and floats serial output.
// - next falling chip select starts a fresh transfer.
// - host changes MOSI on SCLK fall; device samples on SCLK rise.
// - device changes MISO on SCLK fall; host samples on SCLK rise.
// - every word travels most significant bit first.
// - MISO is high impedance whenever no data is being sent.
// - header bits 2..0 are compared with the strapped chip address.
// - strap level gives chip address 0 at ground up to 7 at supply.
// - control bit 2 picks channel-2 output (0) or interrupt (1).
// - interrupt function is open-drain, channel-2 function is push-pull.
// - mask bit 1 enables an event source, 0 disables it.
// - enabled latched flag pulls interrupt low until all such flags clear.
// - writing 1 clears a latched flag, writing 0 leaves it.
// - after reset all sources masked; reset-done can never be masked.
// - pin is channel-2 during reset; reset end sets latched bit 14.
// - mask bit 15 is the conversion-ready control, not a mask bit.
// - live condition bits follow their conditions, set and clear.
// - live layout equals latched, bit 14 shows reset in progress.
// - latched register carries an overheat flag.
// - header bits 14..4 hold register address, bit 3 one means read.
// - header bit 15 set makes a write broadcast, chip address ignored.
// - read data starts on the SCLK fall after the last header bit.
// - control bit 0 set appends a checksum word after read data.
`include "iso_spi_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module isolated_input_spi_irq_front (
    // clock and reset
    input wire CLK_I,
    input wire RESET_N_I,
    // serial port pins
    input wire SCLK_I,
    input wire MOSI_I,
    input wire CS_N_I,
    output reg MISO_O,
    output reg MISO_OE_O,
    // chip address strap, ladder level already quantised to 3 bits
    input wire [2:0] ADDR_STRAP_I,
    // conditions from the input datapath
    input wire CHANNEL2_STATE_I,
    input wire [12:0] EVENT_COND_I,
    input wire OVERHEAT_I,
    input wire CONVERSION_READY_I,
    // shared channel-2 / interrupt pin
    output reg SHARED_PIN_O,
    output reg SHARED_PIN_OE_O
);
    // =========================================================
    // pin synchronisation and edge detection
    wire [2:0] pins_sync;
    wire [2:0] strap_sync;
    reg sclk_prev_reg;

    level_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .async_i({SCLK_I, MOSI_I, CS_N_I}),
        .sync_o(pins_sync)
    );

    level_sync2 #(
        .WIDTH(3)
    ) u_strap_sync (
        .clk_i(CLK_I),
        .async_i(ADDR_STRAP_I),
        .sync_o(strap_sync)
    );

    wire sclk_s = pins_sync[2];
    wire mosi_s = pins_sync[1];
    wire cs_n_s = pins_sync[0];
    wire sclk_rise = sclk_s & ~sclk_prev_reg;
    wire sclk_fall = ~sclk_s & sclk_prev_reg;

    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    // =========================================================
    // internal reset sequence and strap capture
    reg [7:0] busy_cnt_reg;
    reg busy_reg;
    reg [2:0] chip_addr_reg;
    wire busy_done = busy_reg && (busy_cnt_reg == 8'h00);

    // strap is caught at the end of the busy period, never under reset
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            busy_cnt_reg <= `RST_BUSY_CYCLES;
            busy_reg <= 1'b1;
            chip_addr_reg <= 3'h0;
        end else if (busy_reg) begin
            if (busy_done) begin
                busy_reg <= 1'b0;
                chip_addr_reg <= strap_sync;
            end else begin
                busy_cnt_reg <= busy_cnt_reg - 8'h01;
            end
        end
    end

    // =========================================================
    // registers
    reg [15:0] ctrl_reg;
    reg [15:0] mask_reg;
    reg [15:0] latched_reg;
    reg [15:0] live_prev_reg;
    wire [15:0] live_flags;
    wire [15:0] mask_gate;
    wire [15:0] set_vec;
    reg [15:0] clr_vec;

    assign live_flags = {CONVERSION_READY_I, busy_reg, OVERHEAT_I, EVENT_COND_I};

    // bit 15 is conversion-ready control, bit 14 always enabled
    assign mask_gate = {1'b0, 1'b1, mask_reg[13:0]};

    // flags latch on a rising condition; reset-done on busy end
    assign set_vec = {live_flags[15] & ~live_prev_reg[15], busy_done,
        live_flags[13:0] & ~live_prev_reg[13:0]};

    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            live_prev_reg <= 16'h0000;
        end else begin
            live_prev_reg <= live_flags;
        end
    end

    // =========================================================
    // serial frame engine
    reg [5:0] bit_cnt_reg;
    reg [15:0] hdr_reg;
    reg [15:0] rx_reg;
    reg [31:0] tx_shift_reg;
    reg [5:0] tx_left_reg;
    reg wr_accept_reg;
    reg [10:0] wr_addr_reg;
    reg wr_commit;
    reg [15:0] rd_data;
    wire [15:0] crc_value;
    wire frame_on = ~cs_n_s & ~busy_reg;
    wire [15:0] hdr_new = {hdr_reg[14:0], mosi_s};
    wire [15:0] wr_data = {rx_reg[14:0], mosi_s};
    wire [10:0] hdr_reg_addr = hdr_new[`HDR_REG_HI:`HDR_REG_LO];
    wire addr_hit = hdr_new[`HDR_CHIP_HI:`HDR_CHIP_LO] == chip_addr_reg;
    wire hdr_read = hdr_new[`HDR_READ_BIT];
    wire hdr_bcast = hdr_new[`HDR_BCAST_BIT];
    wire hdr_last = sclk_rise && (bit_cnt_reg == `WORD_BITS - 6'h01);

    // read mux, unmapped addresses read as zero
    always @* begin
        if (hdr_reg_addr == `REG_CTRL) begin
            rd_data = ctrl_reg;
        end else if (hdr_reg_addr == `REG_MASK) begin
            rd_data = mask_reg;
        end else if (hdr_reg_addr == `REG_LATCHED) begin
            rd_data = latched_reg;
        end else if (hdr_reg_addr == `REG_LIVE) begin
            rd_data = live_flags;
        end else begin
            rd_data = 16'h0000;
        end
    end

    crc16_word u_crc (
        .data_i(rd_data),
        .crc_o(crc_value)
    );

    always @* begin
        wr_commit = frame_on && sclk_rise && wr_accept_reg &&
            (bit_cnt_reg == `FRAME_LAST_BIT);
    end

    // the frame restarts whenever chip select is high; a frame cut
    // short never reaches the commit point so nothing is written
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            bit_cnt_reg <= 6'h00;
            hdr_reg <= 16'h0000;
            rx_reg <= 16'h0000;
            tx_shift_reg <= 32'h0000_0000;
            tx_left_reg <= 6'h00;
            wr_accept_reg <= 1'b0;
            wr_addr_reg <= 11'h000;
        end else if (!frame_on) begin
            bit_cnt_reg <= 6'h00;
            tx_left_reg <= 6'h00;
            wr_accept_reg <= 1'b0;
        end else begin
            if (sclk_rise) begin
                if (bit_cnt_reg != 6'h3F) begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h01;
                end
                if (bit_cnt_reg < `WORD_BITS) begin
                    hdr_reg <= hdr_new;
                end else begin
                    rx_reg <= wr_data;
                end
            end
            if (hdr_last) begin
                wr_addr_reg <= hdr_reg_addr;
                wr_accept_reg <= ~hdr_read & (addr_hit | hdr_bcast);
                if (hdr_read && addr_hit) begin
                    tx_shift_reg <= {rd_data, crc_value};
                    if (ctrl_reg[`CTRL_CRC_BIT]) begin
                        tx_left_reg <= `CRC_WORD_BITS;
                    end else begin
                        tx_left_reg <= `WORD_BITS;
                    end
                end
            end else if (sclk_fall && tx_left_reg != 6'h00) begin
                tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
                tx_left_reg <= tx_left_reg - 6'h01;
            end
        end
    end

    // =========================================================
    // serial output driver
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            MISO_O <= 1'b0;
            MISO_OE_O <= 1'b0;
        end else if (!frame_on) begin
            MISO_OE_O <= 1'b0;
        end else if (sclk_fall && !hdr_last) begin
            if (tx_left_reg != 6'h00) begin
                MISO_O <= tx_shift_reg[31];
                MISO_OE_O <= 1'b1;
            end else begin
                MISO_OE_O <= 1'b0;
            end
        end
    end

    // =========================================================
    // register writes
    always @* begin
        clr_vec = 16'h0000;
        if (wr_commit && wr_addr_reg == `REG_LATCHED) begin
            clr_vec = wr_data;
        end
    end

    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ctrl_reg <= `CTRL_RESET;
            mask_reg <= `MASK_RESET;
            latched_reg <= `LATCHED_RESET;
        end else begin
            // a new event in the clearing cycle survives the clear
            latched_reg <= (latched_reg & ~clr_vec) | set_vec;
            if (wr_commit) begin
                if (wr_addr_reg == `REG_CTRL) begin
                    ctrl_reg <= wr_data;
                end else if (wr_addr_reg == `REG_MASK) begin
                    mask_reg <= wr_data;
                end
            end
        end
    end

    // =========================================================
    // shared pin
    wire irq_active = |(latched_reg & mask_gate);
    wire pin_irq_mode = ctrl_reg[`CTRL_PIN_MODE_BIT] & ~busy_reg;

    // open drain in interrupt mode: only ever drives low, released otherwise
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            SHARED_PIN_O <= 1'b0;
            SHARED_PIN_OE_O <= 1'b1;
        end else if (pin_irq_mode) begin
            SHARED_PIN_O <= 1'b0;
            SHARED_PIN_OE_O <= irq_active;
        end else begin
            SHARED_PIN_O <= CHANNEL2_STATE_I;
            SHARED_PIN_OE_O <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> iso_spi_defs.vh
`ifndef ISO_SPI_DEFS_VH
`define ISO_SPI_DEFS_VH

// =============================================================
// header word fields
`define HDR_BCAST_BIT 15
`define HDR_REG_HI 14
`define HDR_REG_LO 4
`define HDR_READ_BIT 3
`define HDR_CHIP_HI 2
`define HDR_CHIP_LO 0
`define WORD_BITS 6'h10
`define CRC_WORD_BITS 6'h20
`define FRAME_LAST_BIT 6'h1F

// =============================================================
// register offsets (11-bit register address)
`define REG_CTRL 11'h001
`define REG_MASK 11'h002
`define REG_LATCHED 11'h003
`define REG_LIVE 11'h004

// =============================================================
// field positions and reset values
`define CTRL_CRC_BIT 0
`define CTRL_PIN_MODE_BIT 2
`define CTRL_RESET 16'h0000
`define MASK_RESET 16'h0000
`define LATCHED_RESET 16'h0000
`define READY_BIT 15
`define RESET_FINISHED_FLAG_BIT 14
`define OVERHEAT_BIT 13

// =============================================================
// internal reset sequence and checksum
`define RST_BUSY_CYCLES 8'h20
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021

`endif

// >>> level_sync2.v
`timescale 1ns/10ps
`default_nettype none

// =============================================================
// two flip-flop synchroniser for levels from outside the clock
module level_sync2 #(
    parameter WIDTH = 1
) (
    // clock
    input wire clk_i,
    // async levels in, synchronised levels out
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // meta_reg is read by sync_reg only
    always @(posedge clk_i) begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end

    assign sync_o = sync_reg;
endmodule

`default_nettype wire

// >>> crc16_word.v
`include "iso_spi_defs.vh"
`timescale 1ns/10ps
`default_nettype none

// =============================================================
// checksum of one 16-bit word, bit 15 fed first, all ones start
module crc16_word (
    // word in
    input wire [15:0] data_i,
    // checksum out
    output reg [15:0] crc_o
);
    integer j;
    reg fb;

    always @* begin
        crc_o = `CRC_INIT;
        fb = 1'b0;
        for (j = 15; j >= 0; j = j - 1) begin
            fb = data_i[j] ^ crc_o[15];
            crc_o = {crc_o[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
        end
    end
endmodule

`default_nettype wire

// >>> spi_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// serial master model, clock idles low
module spi_host (
    // serial pins
    output logic sclk_o,
    output logic mosi_o,
    output logic cs_n_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    logic last;
    // a floating line never repeats the last bit
    wire line = miso_oe_i ? miso_i : ~last;
    initial begin
        {sclk_o, mosi_o, last} = 3'b000;
        cs_n_o = 1'b1;
    end
    // low phase kept long so the synchronised reply settles
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = 48'h0000_0000_0000;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_o = tx[47-i];
            #55;
            sclk_o = 1'b1;
            rx = {rx[46:0], line};
            last = line;
            #25;
            sclk_o = 1'b0;
        end
        #55;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #100;
    endtask
endmodule
`default_nettype wire

// >>> front_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checks of the serial front end
module front_chk (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // watched pins
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic CHANNEL2_STATE_I,
    input wire logic MISO_O,
    input wire logic MISO_OE_O,
    input wire logic SHARED_PIN_O,
    input wire logic SHARED_PIN_OE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // age of the raw clock fall; a rise-driven shifter lands outside the window
    logic sclk_reg;
    logic [3:0] age_reg;
    // two synchroniser stages plus the output flop put the change at age 2
    wire fell_late = age_reg == 4'h2;
    always @(posedge CLK_I) begin
        sclk_reg <= SCLK_I;
        if (!RESET_N_I)
            age_reg <= 4'hF;
        else if (sclk_reg && !SCLK_I)
            age_reg <= 4'h0;
        else if (age_reg != 4'hF)
            age_reg <= age_reg + 4'h1;
    end
    reset_busy_a: assert property ($rose(RESET_N_I) |->
        (SHARED_PIN_OE_O && !MISO_OE_O) [*8]) else $error("busy pins wrong");
    open_drain_a: assert property (!SHARED_PIN_OE_O |-> !SHARED_PIN_O)
        else $error("released pin not low");
    push_pull_a: assert property (SHARED_PIN_OE_O && SHARED_PIN_O |->
        $past(CHANNEL2_STATE_I)) else $error("pin high without channel 2");
    read_start_a: assert property ($rose(MISO_OE_O) |-> fell_late)
        else $error("read data not after clock fall");
    shift_out_a: assert property (MISO_OE_O && $past(MISO_OE_O) &&
        $changed(MISO_O) |-> fell_late) else $error("miso moved off fall");
    cs_abort_a: assert property ($rose(CS_N_I) |-> ##[1:6] !MISO_OE_O)
        else $error("miso driven after deselect");
    idle_float_a: assert property (MISO_OE_O |-> !$past(CS_N_I, 6))
        else $error("miso driven while deselected");
    miso_release_a: assert property ($fell(MISO_OE_O) |->
        fell_late || $past(CS_N_I, 2)) else $error("miso released early");
endmodule
bind isolated_input_spi_irq_front front_chk chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .SCLK_I(SCLK_I), .CS_N_I(CS_N_I), .CHANNEL2_STATE_I(CHANNEL2_STATE_I),
    .MISO_O(MISO_O), .MISO_OE_O(MISO_OE_O), .SHARED_PIN_O(SHARED_PIN_O),
    .SHARED_PIN_OE_O(SHARED_PIN_OE_O));
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "iso_spi_defs.vh"
// ==========
// bench
module testbench;
    logic [2:0] strap;
    logic clk, rst_n, ch2, ovh, rdy, oe_seen;
    logic [12:0] ev;
    logic [15:0] lfsr, d;
    logic [47:0] rx;
    int n_fail, tests_run;
    wire sclk, mosi, cs_n, miso, miso_oe, pin, pin_oe;
    spi_host host (.sclk_o(sclk), .mosi_o(mosi), .cs_n_o(cs_n), .miso_i(miso),
        .miso_oe_i(miso_oe));
    isolated_input_spi_irq_front uut (.CLK_I(clk), .RESET_N_I(rst_n), .SCLK_I(sclk),
        .MOSI_I(mosi), .CS_N_I(cs_n), .MISO_O(miso), .MISO_OE_O(miso_oe),
        .ADDR_STRAP_I(strap), .CHANNEL2_STATE_I(ch2), .EVENT_COND_I(ev),
        .OVERHEAT_I(ovh), .CONVERSION_READY_I(rdy), .SHARED_PIN_O(pin),
        .SHARED_PIN_OE_O(pin_oe));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] crc(input logic [15:0] v);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 15; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task frame(input logic b, input logic [10:0] a, input logic r, input logic [2:0] c,
               input logic [15:0] w, input int n);
        host.xfer({b, a, r, c, w, 16'h0000}, n, rx);
    endtask
    task wr(input logic [10:0] a, input logic [15:0] w);
        frame(1'b0, a, 1'b0, strap, w, 32);
    endtask
    task rd(input logic [10:0] a, input logic [15:0] e);
        frame(1'b0, a, 1'b1, strap, 16'h0000, 32);
        check(rx[15:0], e);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge miso_oe) oe_seen = 1'b1;
    initial begin
        #300000;
        n_fail++;
        final_report;
    end
    initial begin
        n_fail = 0;
        tests_run = 0;
        lfsr = 16'h0031;
        {rst_n, ch2, ovh, rdy, oe_seen, ev} = '0;
        strap = 3'h5;
        tick(4);
        check(pin_oe, 1'b1);
        rst_n = 1'b1;
        tick(50);
        rd(`REG_LATCHED, 16'h4000);
        rd(`REG_MASK, `MASK_RESET);
        rd(`REG_CTRL, `CTRL_RESET);
        ev = lfsr[12:0];
        {ovh, rdy} = 2'b11;
        tick(4);
        rd(`REG_LIVE, {3'b101, ev});
        rd(`REG_LATCHED, {3'b111, ev});
        wr(`REG_LATCHED, 16'hA000);
        {ovh, rdy, ev} = '0;
        tick(4);
        rd(`REG_LIVE, 16'h0000);
        rd(`REG_LATCHED, {3'b010, lfsr[12:0]});
        // broadcast from a foreign chip address must still land
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            d = lfsr;
            frame(i[0], `REG_MASK, 1'b0, i[0] ? ~strap : strap, d, 32);
            frame(1'b0, `REG_MASK, 1'b0, ~strap, ~d, 32);
            frame(1'b0, `REG_MASK, 1'b0, strap, ~d, 20);
            rd(`REG_MASK, d);
            oe_seen = 1'b0;
            frame(1'b0, `REG_MASK, 1'b1, ~strap, 16'h0000, 32);
            check(oe_seen, 1'b0);
        end
        wr(`REG_CTRL, 16'h0001);
        frame(1'b0, `REG_MASK, 1'b1, strap, 16'h0000, 48);
        check(rx[31:0], {d, crc(d)});
        frame(1'b0, `REG_MASK, 1'b1, strap, 16'h0000, 24);
        wr(`REG_MASK, 16'h8000);
        wr(`REG_LATCHED, 16'hBFFF);
        wr(`REG_CTRL, 16'h0004);
        check(pin_oe, 1'b1);
        wr(`REG_LATCHED, 16'h4000);
        check(pin_oe, 1'b0);
        {rdy, ev[3]} = 2'b11;
        tick(4);
        check(pin_oe, 1'b0);
        wr(`REG_MASK, 16'h0008);
        check(pin_oe, 1'b1);
        wr(`REG_MASK, 16'h0000);
        check(pin_oe, 1'b0);
        wr(`REG_MASK, 16'h0008);
        wr(`REG_LATCHED, 16'h0008);
        check(pin_oe, 1'b0);
        wr(`REG_CTRL, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            ch2 = lfsr[0];
            tick(2);
            check({pin_oe, pin}, {1'b1, ch2});
        end
        // second reset with a new strap; the old address must go quiet
        {rdy, ev} = '0;
        rst_n = 1'b0;
        strap = 3'h2;
        tick(4);
        check(pin_oe, 1'b1);
        rst_n = 1'b1;
        tick(50);
        rd(`REG_LATCHED, 16'h4000);
        rd(`REG_MASK, `MASK_RESET);
        wr(`REG_MASK, 16'h1234);
        rd(`REG_MASK, 16'h1234);
        oe_seen = 1'b0;
        frame(1'b0, `REG_MASK, 1'b1, 3'h5, 16'h0000, 32);
        check(oe_seen, 1'b0);
        final_report;
    end
endmodule
`default_nettype wire
